/* rsr_pkg.sv */
// constants for the regulator setpoint register bank
// assumes an 8-bit register port driven by the device's serial host interface
package rsr_pkg;
  // ----------------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------------
  localparam logic [7:0] RAIL0_SCALED_VOLTAGE_TARGET_OFS = 8'h3f;
  localparam logic [7:0] LINEAR_REG0_VOLTAGE_OFS = 8'h48;
  localparam logic [7:0] LINEAR_REG0_CONTROL_OFS = 8'h49;
  localparam logic [7:0] LINEAR_REG1_VOLTAGE_OFS = 8'h4a;

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int LR_OFFSET_BIT = 7;
  localparam int LR_CODE_MSB = 6;
  localparam int CTRL_MODE_BIT = 4;
  localparam int CTRL_DISCH_BIT = 3;
  localparam int CTRL_SLOT_MSB = 2;
  localparam int CTRL_W = 5;
  localparam logic [7:0] CTRL_RD_MASK = 8'h1f;

  // ----------------------------------------------------------------------------
  // reset values; the linear regulator voltage and control fields are factory trimmed
  // ----------------------------------------------------------------------------
  localparam logic [7:0] RAIL0_RST = 8'h00;
  localparam logic [7:0] LR0_VOLT_RST = 8'h00;
  localparam logic [7:0] LR0_CTRL_RST = 8'h04;
  localparam logic [7:0] LR1_VOLT_RST = 8'h00;

  // ----------------------------------------------------------------------------
  // voltage decode, in millivolts
  // ----------------------------------------------------------------------------
  localparam int MV_W = 13;
  localparam logic [12:0] BASE_MV = 13'h01f4;
  localparam logic [12:0] STEP_MV = 13'h0019;
  localparam logic [12:0] OFFSET_MV = 13'h052d;
  localparam logic [12:0] RAIL0_MAX_MV = 13'h157c;
  localparam logic [12:0] LR_OFS_MAX_MV = 13'h1388;
  localparam logic [7:0] RAIL0_SAT_CODE = 8'hc8;

  // ----------------------------------------------------------------------------
  // enable field codes
  // ----------------------------------------------------------------------------
  localparam logic [2:0] EN_FORCE_OFF_A = 3'h4;
  localparam logic [2:0] EN_FORCE_OFF_B = 3'h5;
  localparam logic [2:0] EN_FORCE_ON_A = 3'h6;
  localparam logic [2:0] EN_FORCE_ON_B = 3'h7;
endpackage

/* rsr_lin_decode.sv */
// linear regulator target decode: 7-bit code plus offset select to millivolts
// assumes the caller registers the result
`timescale 1ns/10ps
module rsr_lin_decode (
  input wire logic [6:0] code,
  input wire logic offset_sel,
  output logic [12:0] mv
);
  import rsr_pkg::*;
  // ----------------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------------
  always_comb begin
    mv = BASE_MV + 13'(13'(code) * STEP_MV); // [R03]
    if (offset_sel) begin
      mv = mv + OFFSET_MV; // [R04] [R05]
    end
  end
endmodule

/* rsr_regs.sv */
// regulator setpoint register bank with decoded analog control outputs
// assumes an 8-bit register port from the serial host interface, synchronous to CLOCK
// Notes on behaviour
// [R01] rail 0 target code is linear: 0.500V at zero, 25mV per step.
// [R02] rail 0 codes 0xC8 to 0xFF all give 5.500V.
// [R03] linear regulator 7-bit code is linear: 0.500V to 3.675V in 25mV steps.
// [R04] offset bit 7 adds 1.325V to the linear regulator target.
// [R05] with offset set the code spans 1.825V to 5V.
// [R06] control bit 4 picks low-dropout (0) or load-switch (1) mode.
// [R07] control bit 3 discharges the output while regulator 0 is disabled.
// [R08] enable codes 0 to 3 assign regulator 0 to sequencer slots 0 to 3.
// [R09] enable codes 4 and 5 force regulator 0 off.
// [R10] enable codes 6 and 7 force regulator 0 on.
// [R11] control bits 7:5 ignore writes, read zero; other fields read back.
`timescale 1ns/10ps
module rsr_regs #(
  parameter logic [7:0] LR0_VOLT_INIT = rsr_pkg::LR0_VOLT_RST,
  parameter logic [7:0] LR0_CTRL_INIT = rsr_pkg::LR0_CTRL_RST,
  parameter logic [7:0] LR1_VOLT_INIT = rsr_pkg::LR1_VOLT_RST
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic [3:0] SEQ_SLOT_ON,
  output logic [rsr_pkg::MV_W-1:0] RAIL0_TARGET_MV,
  output logic [rsr_pkg::MV_W-1:0] LINREG0_TARGET_MV,
  output logic [rsr_pkg::MV_W-1:0] LINREG1_TARGET_MV,
  output logic LINREG0_LOAD_SWITCH,
  output logic LINREG0_ENABLED,
  output logic LINREG0_DISCHARGE_ON,
  output logic LINREG0_SEQ_ASSIGNED,
  output logic [1:0] LINREG0_SEQ_SLOT
);
  import rsr_pkg::*;

  // ----------------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------------
  logic [7:0] rail0_q, rail0_d;
  logic [7:0] lr0_volt_q, lr0_volt_d;
  logic [CTRL_W-1:0] lr0_ctrl_q, lr0_ctrl_d;
  logic [7:0] lr1_volt_q, lr1_volt_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    rail0_d = rail0_q;
    lr0_volt_d = lr0_volt_q;
    lr0_ctrl_d = lr0_ctrl_q;
    lr1_volt_d = lr1_volt_q;
    rdata_d = rdata_q;
    if (REG_WR) begin
      case (REG_ADDR)
        RAIL0_SCALED_VOLTAGE_TARGET_OFS: rail0_d = REG_WDATA;
        LINEAR_REG0_VOLTAGE_OFS: lr0_volt_d = REG_WDATA;
        LINEAR_REG0_CONTROL_OFS: lr0_ctrl_d = REG_WDATA[CTRL_W-1:0]; // [R11]
        LINEAR_REG1_VOLTAGE_OFS: lr1_volt_d = REG_WDATA;
        default: ;
      endcase
    end
    // a read in the same cycle as a write returns the old value
    if (REG_RD) begin
      case (REG_ADDR)
        RAIL0_SCALED_VOLTAGE_TARGET_OFS: rdata_d = rail0_q;
        LINEAR_REG0_VOLTAGE_OFS: rdata_d = lr0_volt_q;
        LINEAR_REG0_CONTROL_OFS: rdata_d = {3'h0, lr0_ctrl_q}; // [R11]
        LINEAR_REG1_VOLTAGE_OFS: rdata_d = lr1_volt_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // reset can only load constants, so the factory trims are parameters
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rail0_q <= RAIL0_RST;
      lr0_volt_q <= LR0_VOLT_INIT;
      lr0_ctrl_q <= LR0_CTRL_INIT[CTRL_W-1:0];
      lr1_volt_q <= LR1_VOLT_INIT;
      rdata_q <= 8'h00;
    end else begin
      rail0_q <= rail0_d;
      lr0_volt_q <= lr0_volt_d;
      lr0_ctrl_q <= lr0_ctrl_d;
      lr1_volt_q <= lr1_volt_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------------
  // voltage decode
  // ----------------------------------------------------------------------------
  logic [7:0] lr_volt [2];
  logic [MV_W-1:0] lr_mv [2];
  assign lr_volt[0] = lr0_volt_q;
  assign lr_volt[1] = lr1_volt_q;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_lr
      rsr_lin_decode u_dec (
        .code(lr_volt[gi][LR_CODE_MSB:0]),
        .offset_sel(lr_volt[gi][LR_OFFSET_BIT]),
        .mv(lr_mv[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // analog control outputs
  // ----------------------------------------------------------------------------
  logic [MV_W-1:0] rail0_mv_q, rail0_mv_d, lr0_mv_q, lr1_mv_q;
  logic loadsw_q, loadsw_d, en_q, en_d, disch_q, disch_d, assigned_q, assigned_d;
  logic [1:0] slot_q, slot_d;
  logic [2:0] en_field;

  always_comb begin
    en_field = lr0_ctrl_q[CTRL_SLOT_MSB:0];
    // saturate rather than run past the top of the range
    if (rail0_q >= RAIL0_SAT_CODE) begin
      rail0_mv_d = RAIL0_MAX_MV; // [R02]
    end else begin
      rail0_mv_d = BASE_MV + 13'(13'(rail0_q) * STEP_MV); // [R01]
    end
    loadsw_d = lr0_ctrl_q[CTRL_MODE_BIT]; // [R06]
    slot_d = en_field[1:0]; // [R08]
    assigned_d = 1'b0;
    case (en_field)
      EN_FORCE_OFF_A, EN_FORCE_OFF_B: en_d = 1'b0; // [R09]
      EN_FORCE_ON_A, EN_FORCE_ON_B: en_d = 1'b1; // [R10]
      default: begin
        assigned_d = 1'b1; // [R08]
        en_d = SEQ_SLOT_ON[en_field[1:0]]; // [R08]
      end
    endcase
    disch_d = lr0_ctrl_q[CTRL_DISCH_BIT] & ~en_d; // [R07]
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rail0_mv_q <= 13'h0000;
      lr0_mv_q <= 13'h0000;
      lr1_mv_q <= 13'h0000;
      loadsw_q <= 1'b0;
      en_q <= 1'b0;
      disch_q <= 1'b0;
      assigned_q <= 1'b0;
      slot_q <= 2'h0;
    end else begin
      rail0_mv_q <= rail0_mv_d;
      lr0_mv_q <= lr_mv[0];
      lr1_mv_q <= lr_mv[1];
      loadsw_q <= loadsw_d;
      en_q <= en_d;
      disch_q <= disch_d;
      assigned_q <= assigned_d;
      slot_q <= slot_d;
    end
  end

  assign REG_RDATA = rdata_q;
  assign RAIL0_TARGET_MV = rail0_mv_q;
  assign LINREG0_TARGET_MV = lr0_mv_q;
  assign LINREG1_TARGET_MV = lr1_mv_q;
  assign LINREG0_LOAD_SWITCH = loadsw_q;
  assign LINREG0_ENABLED = en_q;
  assign LINREG0_DISCHARGE_ON = disch_q;
  assign LINREG0_SEQ_ASSIGNED = assigned_q;
  assign LINREG0_SEQ_SLOT = slot_q;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  // output flops first load one edge after release, so checks arm one edge late
  logic chk_armed_q;
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      chk_armed_q <= 1'b0;
    end else begin
      chk_armed_q <= 1'b1;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B || !chk_armed_q);

  a_rail0_linear: assert property (rail0_q < 8'hc8 |=> // [R01]
    RAIL0_TARGET_MV == 13'(13'h01f4 + 13'(13'($past(rail0_q)) * 13'h0019)))
    else $error("rail 0 target not linear");
  a_rail0_saturate: assert property (rail0_q >= 8'hc8 |=> RAIL0_TARGET_MV == 13'h157c) // [R02]
    else $error("rail 0 target not saturated");
  a_linreg_plain: assert property (!lr1_volt_q[7] |=> // [R03]
    LINREG1_TARGET_MV == 13'(13'h01f4 + 13'(13'($past(lr1_volt_q[6:0])) * 13'h0019)))
    else $error("linear regulator plain decode wrong");
  a_linreg_offset: assert property (lr0_volt_q[7] |=> // [R04]
    LINREG0_TARGET_MV == 13'(13'h0721 + 13'(13'($past(lr0_volt_q[6:0])) * 13'h0019)))
    else $error("linear regulator offset not added");
  a_offset_range: assert property (lr0_volt_q[7] |=> // [R05]
    LINREG0_TARGET_MV >= 13'h0721 && LINREG0_TARGET_MV <= 13'h1388)
    else $error("offset range exceeded");
  a_mode_select: assert property (##1 LINREG0_LOAD_SWITCH == $past(lr0_ctrl_q[4])) // [R06]
    else $error("mode select mismatch");
  a_discharge_off: assert property (lr0_ctrl_q[3] && lr0_ctrl_q[2:1] == 2'b10 |=> // [R07]
    LINREG0_DISCHARGE_ON && !LINREG0_ENABLED)
    else $error("discharge not applied while disabled");
  a_no_discharge_on: assert property (LINREG0_ENABLED |-> !LINREG0_DISCHARGE_ON) // [R07]
    else $error("discharge while enabled");
  a_slot_assign: assert property (!lr0_ctrl_q[2] |=> LINREG0_SEQ_ASSIGNED && // [R08]
    LINREG0_SEQ_SLOT == $past(lr0_ctrl_q[1:0]) && LINREG0_ENABLED == $past(SEQ_SLOT_ON[lr0_ctrl_q[1:0]]))
    else $error("sequencer slot assignment wrong");
  a_force_off: assert property (lr0_ctrl_q[2:1] == 2'b10 |=> !LINREG0_ENABLED && !LINREG0_SEQ_ASSIGNED) // [R09]
    else $error("force off ignored");
  a_force_on: assert property (lr0_ctrl_q[2:1] == 2'b11 |=> LINREG0_ENABLED && !LINREG0_SEQ_ASSIGNED) // [R10]
    else $error("force on ignored");

  sequence s_ctrl_wr;
    REG_WR && REG_ADDR == 8'h49;
  endsequence
  sequence s_ctrl_rd;
    REG_RD && !REG_WR && REG_ADDR == 8'h49;
  endsequence
  a_ctrl_readback: assert property (s_ctrl_wr ##1 s_ctrl_rd |=> // [R11]
    REG_RDATA == ($past(REG_WDATA, 2) & 8'h1f))
    else $error("control readback wrong");
endmodule

/* rsr_regs_tb_top.sv */
// self-checking testbench for the regulator setpoint register bank
// assumes rsr_pkg and rsr_regs are compiled first; plain one-cycle strobe register port
`timescale 1ns/10ps
module rsr_regs_tb_top;
  import rsr_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [3:0] seq_slot_on = 4'h0;
  logic [7:0] reg_rdata;
  logic [12:0] rail0_mv, lr0_mv, lr1_mv;
  logic ld_sw, lr0_en, disch, seq_asg;
  logic [1:0] seq_slot;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] rd_v;

  rsr_regs uut (.CLOCK(clock), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SEQ_SLOT_ON(seq_slot_on), .RAIL0_TARGET_MV(rail0_mv),
    .LINREG0_TARGET_MV(lr0_mv), .LINREG1_TARGET_MV(lr1_mv), .LINREG0_LOAD_SWITCH(ld_sw),
    .LINREG0_ENABLED(lr0_en), .LINREG0_DISCHARGE_ON(disch), .LINREG0_SEQ_ASSIGNED(seq_asg),
    .LINREG0_SEQ_SLOT(seq_slot));

  always #4 clock = ~clock;

  // ----------------------------------------------------------------------------
  // bus tasks and comparisons
  // ----------------------------------------------------------------------------
  // decoded outputs settle one edge after the write edge; wait two edges before returning
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    #1;
    d = reg_rdata;
  endtask

  task automatic cmp_reg(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmp_mv(input string nm, input logic [12:0] e, input logic [12:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmp_bit(input string nm, input logic e, input logic s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask

  // 500 mV base, 25 mV step, 1325 mV offset, 5500 mV ceiling
  function automatic logic [12:0] lin_mv(input logic [7:0] c);
    return 13'h01f4 + 13'h0019 * {6'h00, c[6:0]} + (c[7] ? 13'h052d : 13'h0000);
  endfunction

  function automatic logic [12:0] rail_mv(input logic [7:0] c);
    return (c >= 8'hc8) ? 13'h157c : 13'h01f4 + 13'h0019 * {5'h00, c};
  endfunction

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    rd(8'h3f, rd_v);
    cmp_reg("rail0 reset", 8'h00, rd_v);
    rd(8'h48, rd_v);
    cmp_reg("lr0 volt reset", LR0_VOLT_RST, rd_v);
    rd(8'h49, rd_v);
    cmp_reg("lr0 ctrl reset", LR0_CTRL_RST & 8'h1f, rd_v);
    rd(8'h4a, rd_v);
    cmp_reg("lr1 volt reset", LR1_VOLT_RST, rd_v);
    cmp_mv("rail0 mv reset", rail_mv(8'h00), rail0_mv);
    cmp_bit("lr0 enabled reset", 1'b0, lr0_en);
    $display("test reset done");
  endtask

  task automatic t_rail0();
    logic [7:0] codes [5] = '{8'h00, 8'h01, 8'hc7, 8'hc8, 8'hff};
    foreach (codes[i]) begin
      wr(8'h3f, codes[i]);
      cmp_mv("rail0 mv", rail_mv(codes[i]), rail0_mv);
      rd(8'h3f, rd_v);
      cmp_reg("rail0 readback", codes[i], rd_v);
    end
    $display("test rail0 done");
  endtask

  task automatic t_linreg();
    logic [7:0] codes [5] = '{8'h00, 8'h7f, 8'h80, 8'hff, 8'h2a};
    foreach (codes[i]) begin
      wr(8'h48, codes[i]);
      wr(8'h4a, codes[i] ^ 8'h80);
      cmp_mv("lr0 mv", lin_mv(codes[i]), lr0_mv);
      cmp_mv("lr1 mv", lin_mv(codes[i] ^ 8'h80), lr1_mv);
      rd(8'h48, rd_v);
      cmp_reg("lr0 volt readback", codes[i], rd_v);
      rd(8'h4a, rd_v);
      cmp_reg("lr1 volt readback", codes[i] ^ 8'h80, rd_v);
    end
    $display("test linreg done");
  endtask

  task automatic t_ctrl();
    logic [7:0] v;
    logic on;
    for (int k = 0; k < 16; k++) begin
      v = {3'h7, 1'(k), 1'(k >> 1) ^ 1'(k >> 3), 3'(k >> 1)};
      seq_slot_on <= k[0] ? (4'h1 << v[1:0]) : ~(4'h1 << v[1:0]);
      wr(8'h49, v);
      on = v[2] ? v[1] : k[0];
      cmp_bit("load switch", v[4], ld_sw);
      cmp_bit("enabled", on, lr0_en);
      cmp_bit("discharge", v[3] & ~on, disch);
      cmp_bit("seq assigned", ~v[2], seq_asg);
      cmp_mv("seq slot", {11'h000, v[1:0]}, {11'h000, seq_slot});
      rd(8'h49, rd_v);
      cmp_reg("ctrl readback", v & 8'h1f, rd_v);
    end
    $display("test ctrl done");
  endtask

  // unmapped writes must leave neighbours alone and read zero
  task automatic t_unmapped();
    wr(8'h40, 8'hff);
    rd(8'h40, rd_v);
    cmp_reg("unmapped read", 8'h00, rd_v);
    rd(8'h3f, rd_v);
    cmp_reg("rail0 kept", 8'hff, rd_v);
    $display("test unmapped done");
  endtask

  // write then read on the next edge, and a read in the same cycle as a write
  task automatic t_b2b();
    @(posedge clock);
    reg_addr <= 8'h49;
    reg_wdata <= 8'hf5;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    #1;
    cmp_reg("ctrl back to back", 8'h15, reg_rdata);
    @(posedge clock);
    reg_wdata <= 8'h0a;
    reg_wr <= 1'b1;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clock);
    #1;
    cmp_reg("ctrl read during write", 8'h15, reg_rdata);
    rd(8'h49, rd_v);
    cmp_reg("ctrl after write", 8'h0a, rd_v);
    $display("test back to back done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      $display("ERROR timeout expected done seen hang");
      summarize();
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    t_rail0();
    t_linreg();
    t_ctrl();
    t_unmapped();
    t_b2b();
    summarize();
  end
endmodule
